// file: core/ddc_defines.svh
// bit positions, reset values and timing counts of the driver control bank
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// ---------------------------------------------------------------
// frame and word layout
// ---------------------------------------------------------------
`define DDC_WORD_W       24
`define DDC_FRAME_BITS   5'h18
`define DDC_STAGES       9
`define DDC_BIT_SEL      0
`define DDC_BIT_LS_A     1
`define DDC_BIT_HS_A     2
`define DDC_BIT_LS_B     3
`define DDC_BIT_HS_B     4
`define DDC_BIT_LS_C     5
`define DDC_BIT_HS_C     6
`define DDC_BIT_HS_D     14
`define DDC_BIT_HS_E     15
`define DDC_BIT_HS_F     17
`define DDC_BIT_MON_LO   18
`define DDC_BIT_MON_HI   19
`define DDC_BIT_DUTY     21
`define DDC_BIT_RESET    22
`define DDC_BIT_ENABLE   23
`define DDC_ST_NOERR     0
`define DDC_ST_NOTRDY    18
`define DDC_ST_TW        19
`define DDC_ST_ONE       23
`define DDC_CTRL_RST     24'h000000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DDC_CLK_NS        8
`define DDC_STARTUP_NS    20000
`define DDC_STARTUP_CYC   ((`DDC_STARTUP_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_REC_PERIOD_NS 8000
`define DDC_REC_OFF12_CYC ((`DDC_REC_PERIOD_NS * 88 / 100) / `DDC_CLK_NS)
`define DDC_REC_OFF25_CYC ((`DDC_REC_PERIOD_NS * 75 / 100) / `DDC_CLK_NS)

`endif

// file: core/ddc_pkg.sv
// types shared by the driver control bank
package ddc_pkg;
  typedef enum {DDC_STANDBY, DDC_SETTLE, DDC_ACTIVE} ddc_mode_e;
  typedef logic [23:0] ddc_word_t;
  typedef logic [8:0]  ddc_stage_t;
endpackage

// file: core/ddc_link_if.sv
// words passed between the serial link domain and the core domain
`timescale 1ns/1ps
interface ddc_link_if;
  import ddc_pkg::*;
  ddc_word_t rx_word;
  logic      rx_len_ok;
  ddc_word_t tx_word0;
  ddc_word_t tx_word1;
  modport link (output rx_word, output rx_len_ok, input tx_word0, input tx_word1);
  modport core (input rx_word, input rx_len_ok, output tx_word0, output tx_word1);
endinterface

// file: core/ddc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ddc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: core/ddc_spi_link.sv
// serial link shifter on the link clock, lsb first
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_spi_link import ddc_pkg::*; (
  // reset
  input  wire logic arst_n,
  // serial pins
  input  wire logic spi_clk,
  input  wire logic chip_select_low_n,
  input  wire logic spi_din,
  output logic      spi_dout,
  // words to and from the core
  ddc_link_if.link  lif
);
  logic       started_q;
  logic       frame_clr;
  logic [4:0] cnt_q;
  ddc_word_t  in_sh_q;
  ddc_word_t  out_sh_q;

  // ---------------------------------------------------------------
  // frame start, cleared by select going high or by reset
  // ---------------------------------------------------------------
  assign frame_clr = chip_select_low_n | !arst_n;

  always_ff @(posedge spi_clk or posedge frame_clr) begin
    if (frame_clr) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receive and load; values stay frozen while the clock stands
  // ---------------------------------------------------------------
  always_ff @(posedge spi_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 5'h00;
      in_sh_q  <= '0;
      out_sh_q <= '0;
    end else begin
      in_sh_q <= {spi_din, in_sh_q[23:1]};
      if (!started_q) begin
        cnt_q    <= 5'h01;
        out_sh_q <= spi_din ? lif.tx_word1 : lif.tx_word0; // RULE13
      end else if (cnt_q != 5'h1F) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit on falling edges
  // ---------------------------------------------------------------
  always_ff @(negedge spi_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_dout <= 1'b0;
    end else if (cnt_q < `DDC_FRAME_BITS) begin
      spi_dout <= out_sh_q[cnt_q];
    end else begin
      spi_dout <= 1'b0;
    end
  end

  assign lif.rx_word   = in_sh_q;
  assign lif.rx_len_ok = (cnt_q == `DDC_FRAME_BITS); // RULE14
endmodule

// file: core/ddc_bank0.sv
// control word zero and status words of the serial actuator driver
// Contract
// RULE1: a drive bit written one turns its stage on; zero keeps it off
// RULE2: drive bits 1..6 are bridges A..C low/high, 14,15,17 are D,E,F
// RULE3: with pulse enable set, drive only while the selected pulse input is high
// RULE4: never switch both stages of one half bridge on together
// RULE5: over-current sets the output's status flag and switches it off
// RULE6: with recovery enabled re-enable after a delay; duty from bit 21
// RULE7: without recovery the host clears the flag before the output returns
// RULE8: status bit 0 is the NOR of status bits 1 to 22 of both words
// RULE9: status bit 19 latches temperature warning until the host clears it
// RULE10: leaving standby starts a settle timer, sets bit 18, holds outputs off
// RULE11: the not-ready flag clears by itself when the settle time ends
// RULE12: control bits 19,18 route F, A, D or E to the current monitor
// RULE13: first serial bit selects the control and status word, zero is word zero
// RULE14: commit only at select rising edge and only after exactly 24 clocks
// RULE15: control bit 22 clears all status flags after the frame ends; the code leaves the not-ready flag to its settle timer
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_bank0 import ddc_pkg::*; #(
  parameter int unsigned STARTUP_CYC = `DDC_STARTUP_CYC,
  parameter int unsigned REC_OFF12   = `DDC_REC_OFF12_CYC,
  parameter int unsigned REC_OFF25   = `DDC_REC_OFF25_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // serial link
  input  wire logic       spi_clk,
  input  wire logic       chip_select_low_n,
  input  wire logic       spi_din,
  output logic            spi_dout,
  output logic            spi_dout_oe,
  // external pulse inputs
  input  wire logic       pulse_input_first,
  input  wire logic       pulse_input_second,
  // analog sense
  input  wire logic [8:0] oc_detect,
  input  wire logic       temperature_warning_in,
  // settings held by the neighbouring bank
  input  wire logic [8:0] pwm_enable,
  input  wire logic [8:0] pwm_select_second,
  input  wire logic [8:0] oc_recovery_enable,
  // output stages and monitor
  output logic [8:0]      stage_on,
  output logic [3:0]      monitor_route,
  output logic            device_active
);
  localparam int SW = $clog2(STARTUP_CYC + 1);
  localparam int RM = (REC_OFF12 > REC_OFF25) ? REC_OFF12 : REC_OFF25;
  localparam int RW = $clog2(RM + 1);
  localparam int POS [9] = '{`DDC_BIT_LS_A, `DDC_BIT_HS_A, `DDC_BIT_LS_B, // RULE2
                             `DDC_BIT_HS_B, `DDC_BIT_LS_C, `DDC_BIT_HS_C,
                             `DDC_BIT_HS_D, `DDC_BIT_HS_E, `DDC_BIT_HS_F};

  if (STARTUP_CYC < 1 || REC_OFF12 < 1 || REC_OFF25 < 1) begin : g_chk
    $error("ddc_bank0: timing counts must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ddc_link_if     lif ();
  logic           csn_s;
  logic           sel_s;
  logic           csn_prev_q;
  logic [11:0]    pins_s;
  logic           pulse_input_first_s;
  logic           pulse_input_second_s;
  ddc_stage_t     oc_s;
  logic           tw_s;
  logic           commit;
  logic           go_active;
  logic           go_standby;
  logic           clr_any;
  ddc_mode_e      mode_q;
  logic [SW-1:0]  settle_cnt_q;
  logic           not_ready;
  ddc_word_t      ctrl0_q;
  ddc_stage_t     oc_flag_q;
  logic           tw_q;
  ddc_stage_t     drv;
  ddc_stage_t     blocked;
  ddc_stage_t     pwm_lvl;
  ddc_stage_t     pwm_block;
  ddc_stage_t     oc_hard;
  ddc_stage_t     stage_d;
  ddc_stage_t     stage_q;
  logic [3:0]     route_d;
  logic [3:0]     route_q;
  ddc_word_t      st0;
  ddc_word_t      st1;
  ddc_word_t      tx0_q;
  ddc_word_t      tx1_q;
  logic           oe_q;

  // ---------------------------------------------------------------
  // link domain and synchronisers
  // ---------------------------------------------------------------
  ddc_spi_link u_link (
    .arst_n            (arst_n),
    .spi_clk           (spi_clk),
    .chip_select_low_n (chip_select_low_n),
    .spi_din           (spi_din),
    .spi_dout          (spi_dout),
    .lif               (lif.link)
  );

  ddc_sync #(.W(1)) u_csn_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (!chip_select_low_n),
    .q      (sel_s)
  );

  ddc_sync #(.W(12)) u_pin_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({temperature_warning_in, oc_detect, pulse_input_second, pulse_input_first}),
    .q      (pins_s)
  );

  assign pulse_input_first_s = pins_s[0];
  assign pulse_input_second_s = pins_s[1];
  assign oc_s   = pins_s[10:2];
  assign tw_s   = pins_s[11];
  // select synchronised active high so that reset reads as deselected
  assign csn_s  = !sel_s;

  // ---------------------------------------------------------------
  // frame commit; link words are frozen while select is high
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      csn_prev_q <= 1'b1;
    end else begin
      csn_prev_q <= csn_s;
    end
  end

  assign commit     = csn_s && !csn_prev_q && lif.rx_len_ok; // RULE14
  assign go_active  = commit && lif.rx_word[`DDC_BIT_ENABLE];
  assign go_standby = commit && !lif.rx_word[`DDC_BIT_ENABLE];
  assign clr_any    = go_standby || (commit && !lif.rx_word[`DDC_BIT_SEL] // RULE15
                                     && lif.rx_word[`DDC_BIT_RESET]);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_q <= `DDC_CTRL_RST;
    end else if (go_standby) begin
      ctrl0_q <= `DDC_CTRL_RST;
    end else if (go_active && !lif.rx_word[`DDC_BIT_SEL]) begin // RULE13
      ctrl0_q <= lif.rx_word;
    end
  end

  // ---------------------------------------------------------------
  // standby, settle and active
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q       <= DDC_STANDBY;
      settle_cnt_q <= '0;
    end else begin
      case (mode_q)
        DDC_STANDBY: begin
          if (go_active) begin
            mode_q       <= DDC_SETTLE; // RULE10
            settle_cnt_q <= SW'(STARTUP_CYC - 1);
          end
        end
        DDC_SETTLE: begin
          if (go_standby) begin
            mode_q <= DDC_STANDBY;
          end else if (settle_cnt_q == '0) begin
            mode_q <= DDC_ACTIVE; // RULE11
          end else begin
            settle_cnt_q <= settle_cnt_q - 1'b1;
          end
        end
        DDC_ACTIVE: begin
          if (go_standby) begin
            mode_q <= DDC_STANDBY;
          end
        end
        default: begin
          mode_q <= DDC_STANDBY;
        end
      endcase
    end
  end

  assign not_ready = (mode_q == DDC_SETTLE);

  // ---------------------------------------------------------------
  // status flags; a new event wins over a clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oc_flag_q <= '0;
      tw_q      <= 1'b0;
    end else begin
      oc_flag_q <= oc_s | (oc_flag_q & ~{9{clr_any}}); // RULE5
      tw_q      <= tw_s | (tw_q & !clr_any); // RULE9
    end
  end

  // ---------------------------------------------------------------
  // per-output over-current blanking and recovery
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `DDC_STAGES; g++) begin : g_rec
    logic [RW-1:0] cnt_q;
    logic          blk_q;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q <= '0;
        blk_q <= 1'b0;
      end else if (oc_s[g] && !blk_q) begin
        blk_q <= 1'b1; // RULE5
        cnt_q <= ctrl0_q[`DDC_BIT_DUTY] ? RW'(REC_OFF25 - 1) : RW'(REC_OFF12 - 1); // RULE6
      end else if (blk_q) begin
        if (oc_recovery_enable[g]) begin
          if (cnt_q == '0) begin
            blk_q <= 1'b0; // RULE6
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end else if (!oc_flag_q[g] && !oc_s[g]) begin
          blk_q <= 1'b0; // RULE7
        end
      end
    end
    assign blocked[g] = blk_q;
    assign drv[g]     = ctrl0_q[POS[g]];
    assign pwm_lvl[g] = pwm_select_second[g] ? pulse_input_second_s : pulse_input_first_s;
  end

  assign pwm_block = pwm_enable & ~pwm_lvl;
  assign oc_hard   = oc_s & ~oc_recovery_enable;

  // ---------------------------------------------------------------
  // stage drive
  // ---------------------------------------------------------------
  always_comb begin
    stage_d = drv & ~blocked & ~pwm_block; // RULE1 RULE3
    if (mode_q != DDC_ACTIVE) begin
      stage_d = '0; // RULE10
    end
    for (int k = 0; k < 3; k++) begin
      if (drv[2*k] && drv[2*k+1]) begin
        stage_d[2*k]   = 1'b0; // RULE4
        stage_d[2*k+1] = 1'b0;
      end
    end
  end

  always_comb begin
    case (ctrl0_q[`DDC_BIT_MON_HI:`DDC_BIT_MON_LO]) // RULE12
      2'h0:    route_d = 4'h8;
      2'h2:    route_d = 4'h1;
      2'h1:    route_d = 4'h2;
      2'h3:    route_d = 4'h4;
      default: route_d = 4'h8;
    endcase
  end

  // ---------------------------------------------------------------
  // status words and snapshot for the link
  // ---------------------------------------------------------------
  always_comb begin
    st0 = '0;
    st1 = '0;
    for (int i = 0; i < `DDC_STAGES; i++) begin
      st0[POS[i]] = oc_flag_q[i];
    end
    st0[`DDC_ST_NOTRDY] = not_ready;
    st0[`DDC_ST_TW]     = tw_q;
    st0[`DDC_ST_ONE]    = 1'b1;
    st1[`DDC_ST_NOTRDY] = not_ready;
    st1[`DDC_ST_TW]     = tw_q;
    st1[`DDC_ST_ONE]    = 1'b1;
    st0[`DDC_ST_NOERR]  = ~|{st0[22:1], st1[22:1]}; // RULE8
    st1[`DDC_ST_NOERR]  = st0[`DDC_ST_NOERR];
  end

  // frozen while select is low so the link loads a stable word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx0_q <= '0;
      tx1_q <= '0;
    end else if (csn_s) begin
      tx0_q <= st0;
      tx1_q <= st1;
    end
  end

  assign lif.tx_word0 = tx0_q;
  assign lif.tx_word1 = tx1_q;

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= '0;
      route_q <= 4'h8;
      oe_q    <= 1'b0;
    end else begin
      stage_q <= stage_d;
      route_q <= route_d;
      oe_q    <= !csn_s;
    end
  end

  assign stage_on      = stage_q;
  assign monitor_route = route_q;
  assign spi_dout_oe   = oe_q;
  assign device_active = tx0_q[`DDC_ST_ONE];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_bridge_exclusive: assert property ( // RULE4
    (stage_q[0] && stage_q[1]) == 0 && (stage_q[2] && stage_q[3]) == 0 && (stage_q[4] && stage_q[5]) == 0)
    else $error("both stages of a half bridge are on");

  a_drive_follows_bit: assert property ( // RULE1
    (mode_q == DDC_ACTIVE && (drv & ~blocked & ~pwm_block) == 9'h001) |=> stage_q[0])
    else $error("low side A not driven although enabled");

  a_pwm_gates_stage: assert property ( // RULE3
    (stage_q & $past(pwm_block)) == '0)
    else $error("stage on while its pulse input is low");

  a_oc_flag_set: assert property ( // RULE5
    (oc_s != '0) |=> ((oc_flag_q & $past(oc_s)) == $past(oc_s)))
    else $error("over-current flag not latched");

  a_oc_stage_off: assert property ( // RULE5
    (oc_hard != '0) |-> ##2 ((stage_q & $past(oc_hard, 2)) == '0))
    else $error("stage still on after over-current");

  a_noerr_nor: assert property ( // RULE8
    st0[`DDC_ST_NOERR] == !((|oc_flag_q) || not_ready || tw_q))
    else $error("no-error bit disagrees with flags");

  a_tw_latched: assert property ( // RULE9
    (tw_q && !clr_any) |=> tw_q)
    else $error("temperature warning lost without clear");

  a_settle_off: assert property ( // RULE10
    not_ready |=> stage_q == '0)
    else $error("stage on during settle time");

  a_settle_end: assert property ( // RULE11
    (not_ready && settle_cnt_q == '0 && !go_standby) |=> !not_ready)
    else $error("not-ready flag did not clear at end of settle");

  a_route_f: assert property ( // RULE12
    (ctrl0_q[19:18] == 2'h0) |=> (route_q == 4'h8))
    else $error("monitor route wrong for code zero");

  a_short_frame: assert property ( // RULE14
    (csn_s && !csn_prev_q && !lif.rx_len_ok) |=> $stable(ctrl0_q)
      && ($stable(mode_q) || ($past(mode_q) == DDC_SETTLE && mode_q == DDC_ACTIVE)))
    else $error("control changed by a bad-length frame");

  a_reset_clears: assert property ( // RULE15
    clr_any |=> (oc_flag_q == $past(oc_s)) && (tw_q == $past(tw_s)))
    else $error("reset bit did not clear the flags");

  c_commit: cover property (commit && !lif.rx_word[0]);
  c_recovery: cover property ($fell(blocked[6]) && oc_recovery_enable[6]);
  c_ready: cover property ($fell(not_ready));
  c_conflict: cover property (drv[0] && drv[1] && mode_q == DDC_ACTIVE);
endmodule

// file: tb/ddc_host_model.sv
// host-side serial master model driving frames into the driver control bank
`timescale 1ns/1ps
module ddc_host_model import ddc_pkg::*; (
  // serial pins
  output logic      spi_clk,
  output logic      chip_select_low_n,
  output logic      spi_din,
  input  wire logic spi_dout,
  input  wire logic spi_dout_oe
);
  initial begin
    spi_clk           = 1'b0;
    chip_select_low_n = 1'b1;
    spi_din           = 1'b1;
  end

  // ---------------------------------------------------------------
  // one frame of n link clocks, lsb first; returns status bits 1..23
  // ---------------------------------------------------------------
  task automatic frame(input ddc_word_t w, input int n, output ddc_word_t r);
    r = '0;
    chip_select_low_n = 1'b0;
    // odd offset keeps the link edges off the system clock phase
    #37.3;
    for (int i = 0; i < n; i++) begin
      spi_din = w[i % 24];
      #24 spi_clk = 1'b1;
      if (i > 0 && i < 24 && spi_dout_oe === 1'b1) begin
        r[i] = spi_dout;
      end
      #24 spi_clk = 1'b0;
    end
    #24 chip_select_low_n = 1'b1;
    // released data line must not keep its last value
    spi_din = ~spi_din;
    #56;
  endtask
endmodule

// file: tb/ddc_bank0_bench.sv
// self-checking bench of the driver control bank with a host model
`timescale 1ns/1ps
module ddc_bank0_bench import ddc_pkg::*; ();
  localparam int unsigned SU  = 400;
  localparam int unsigned R12 = 9;
  localparam int unsigned R25 = 6;
  localparam ddc_word_t   EN  = 24'h800000;
  logic       clock, arst_n, spi_clk, chip_select_low_n, spi_din, spi_dout, spi_dout_oe;
  logic       pulse_input_first, pulse_input_second, temperature_warning_in, device_active;
  logic [8:0] oc_detect, pwm_enable, pwm_select_second, oc_recovery_enable, stage_on;
  logic [3:0] monitor_route;
  ddc_word_t  rx;
  int         num_errors;
  int         n_checks;

  initial clock = 1'b0;
  always #4 clock = ~clock;

  ddc_bank0 #(.STARTUP_CYC(SU), .REC_OFF12(R12), .REC_OFF25(R25)) dut_u (
    .clock(clock), .arst_n(arst_n), .spi_clk(spi_clk), .chip_select_low_n(chip_select_low_n),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
    .pulse_input_first(pulse_input_first), .pulse_input_second(pulse_input_second),
    .oc_detect(oc_detect), .temperature_warning_in(temperature_warning_in),
    .pwm_enable(pwm_enable), .pwm_select_second(pwm_select_second),
    .oc_recovery_enable(oc_recovery_enable), .stage_on(stage_on),
    .monitor_route(monitor_route), .device_active(device_active));

  ddc_host_model host_u (.spi_clk(spi_clk), .chip_select_low_n(chip_select_low_n),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input ddc_word_t w, input int n);
    host_u.frame(w, n, rx);
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_settle();
    wr(EN | 24'h004000, 24);
    chk(stage_on, 9'h000);
    wr(EN | 24'h004000, 24);
    chk(rx, 24'h840000);
    chk(stage_on, 9'h000);
    tick(SU);
    chk(stage_on, 9'h040);
    wr(EN | 24'h004000, 24);
    chk(rx, 24'h800000);
  endtask

  task automatic t_drive();
    int pos [9] = '{1, 2, 3, 4, 5, 6, 14, 15, 17};
    for (int k = 0; k < 9; k++) begin
      wr(EN | (24'h000001 << pos[k]), 24);
      chk(stage_on, 9'h001 << k);
    end
    wr(EN, 24);
    chk(stage_on, 9'h000);
    for (int b = 0; b < 3; b++) begin
      wr(EN | (24'h000006 << (2 * b)), 24);
      chk(stage_on, 9'h000);
    end
  endtask

  task automatic t_len();
    wr(EN | 24'h008000, 24);
    chk(stage_on, 9'h080);
    wr(EN | 24'h020000, 23);
    chk(stage_on, 9'h080);
    wr(EN | 24'h020000, 25);
    chk(stage_on, 9'h080);
  endtask

  task automatic t_route();
    logic [3:0] rt [4];
    rt = '{4'h8, 4'h2, 4'h1, 4'h4};
    for (int c = 0; c < 4; c++) begin
      wr(EN | (ddc_word_t'(c) << 18), 24);
      chk(monitor_route, rt[c]);
    end
  endtask

  task automatic t_pwm();
    wr(EN | 24'h004000, 24);
    pwm_enable = 9'h040;
    for (int s = 0; s < 2; s++) begin
      pwm_select_second = s ? 9'h040 : 9'h000;
      pulse_input_first = s;
      pulse_input_second = !s;
      tick(6);
      chk(stage_on, 9'h000);
      pulse_input_first = !s;
      pulse_input_second = s;
      tick(6);
      chk(stage_on, 9'h040);
    end
    pwm_enable = 9'h000;
  endtask

  task automatic t_oc();
    wr(EN | 24'h004000, 24);
    oc_detect = 9'h040;
    tick(6);
    chk(stage_on, 9'h000);
    wr(EN | 24'h004000, 24);
    chk(rx, 24'h804000);
    wr(EN | 24'h004001, 24);
    chk(rx, 24'h800000);
    oc_detect = 9'h000;
    tick(6);
    chk(stage_on, 9'h000);
    wr(EN | 24'h404000, 24);
    chk(stage_on, 9'h040);
    wr(EN | 24'h004000, 24);
    chk(rx, 24'h800000);
  endtask

  task automatic t_rec();
    int off [2];
    int w;
    oc_recovery_enable = 9'h040;
    for (int d = 0; d < 2; d++) begin
      wr(EN | 24'h004000 | (ddc_word_t'(d) << 21), 24);
      oc_detect = 9'h040;
      w = 0;
      while (stage_on[6] === 1'b1 && w < 20) begin
        tick(1);
        w++;
      end
      oc_detect = 9'h000;
      off[d] = 0;
      while (stage_on[6] !== 1'b1 && off[d] < 60) begin
        tick(1);
        off[d]++;
      end
      chk(stage_on, 9'h040);
    end
    chk(off[0] - off[1], R12 - R25);
    oc_recovery_enable = 9'h000;
    wr(EN | 24'h400000, 24);
  endtask

  task automatic t_warn();
    temperature_warning_in = 1'b1;
    tick(5);
    temperature_warning_in = 1'b0;
    tick(5);
    wr(EN, 24);
    chk(rx, 24'h880000);
    wr(EN | 24'h004001, 24);
    chk(rx, 24'h880000);
    chk(stage_on, 9'h000);
    wr(EN | 24'h400000, 24);
    wr(EN, 24);
    chk(rx, 24'h800000);
  endtask

  initial begin
    num_errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    pulse_input_first = 1'b0;
    pulse_input_second = 1'b0;
    temperature_warning_in = 1'b0;
    oc_detect = 9'h000;
    pwm_enable = 9'h000;
    pwm_select_second = 9'h000;
    oc_recovery_enable = 9'h000;
    tick(16);
    arst_n = 1'b1;
    chk(stage_on, 9'h000);
    chk(monitor_route, 4'h8);
    chk(spi_dout_oe, 1'b0);
    chk(device_active, 1'b0);
    tick(4);
    chk(device_active, 1'b1);
    chk(spi_dout_oe, 1'b0);
    t_settle();
    t_drive();
    t_len();
    t_route();
    t_pwm();
    t_oc();
    t_rec();
    t_warn();
    conclude();
  end

  initial begin
    #300us;
    num_errors++;
    conclude();
  end
endmodule
